//--- bench/lft_ext_clock_model.sv
`timescale 1ns/1ps
module lft_ext_clock_model #(
   parameter int HALF = 5
) (
   input  wire logic i_clk,
   input  wire logic i_en,
   output logic      o_pin = 1'b0
);
   int cnt = 0;

   // External clock, low while disabled
   always @(posedge i_clk) begin
      if (!i_en) begin
         cnt   <= 0;
         o_pin <= 1'b0;
      end else if (cnt == HALF - 1) begin
         cnt   <= 0;
         o_pin <= ~o_pin;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule

//--- bench/lft_timer_properties.sv
`timescale 1ns/1ps
module lft_timer_properties
   import lft_pkg::*;
(
   // Clock, reset and register port
   input wire logic        i_clk,
   input wire logic        i_reset,
   input wire logic [1:0]  i_addr,
   input wire logic [7:0]  i_wdata,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [7:0]  o_rdata,
   // Pins, oscillator enable and count
   input wire logic        o_osc_input_pin_oe,
   input wire logic        o_osc_output_pin_oe,
   input wire logic        o_sec_osc_enable,
   input wire logic [15:0] o_count
);
   logic [5:0]  ctrl_q;
   logic [6:0]  quiet;
   logic [7:0]  gap;
   logic [15:0] prev;

   // Mirror of control, cycles since a write, cycles since a count change
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         ctrl_q <= 6'h00;
         quiet  <= 7'h00;
         gap    <= 8'h00;
         prev   <= 16'h0000;
      end else begin
         if (i_wr && i_addr == LFT_ADDR_CTRL) begin
            ctrl_q <= i_wdata[5:0];
         end
         quiet <= i_wr ? 7'h00 : ((quiet == 7'h7f) ? quiet : quiet + 7'h01);
         gap   <= (o_count != prev) ? 8'h00 : ((gap == 8'hff) ? gap : gap + 8'h01);
         prev  <= o_count;
      end
   end

   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);

   sequence s_wr_ctrl;
      i_wr && i_addr == LFT_ADDR_CTRL;
   endsequence
   sequence s_rd_ctrl;
      i_rd && i_addr == LFT_ADDR_CTRL;
   endsequence
   sequence s_idle;
      !ctrl_q[0] && !i_wr;
   endsequence

   a_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00)
      else $error("read data not idle");
   a_ctrl_readback: assert property (s_wr_ctrl ##1 !i_wr ##1 s_rd_ctrl
      |=> (o_rdata & 8'hbf) == ($past(i_wdata, 3) & 8'hbf))
      else $error("control readback wrong");
   a_osc_en_copy: assert property (s_wr_ctrl |=> o_sec_osc_enable == ctrl_q[3])
      else $error("oscillator enable wrong");
   a_pins_input: assert property (ctrl_q[0] |-> !o_osc_input_pin_oe && !o_osc_output_pin_oe)
      else $error("pin driven while running");
   a_pin_read_zero: assert property (ctrl_q[0] && i_rd && i_addr == LFT_ADDR_PORT
      |=> o_rdata == 8'h00)
      else $error("pin read not zero");
   a_count_stopped: assert property (s_idle ##1 s_idle |=> $stable(o_count))
      else $error("count moved while stopped");
   a_count_step: assert property (o_count != prev && quiet != 7'h00
      |-> o_count == prev + 16'h0001)
      else $error("count step not one");
   a_timer_period: assert property (o_count != prev && quiet >= 7'd100
      && ctrl_q[1:0] == 2'h1 |-> gap == (8'h04 << ctrl_q[5:4]) - 8'h01)
      else $error("timer period wrong");
endmodule

bind lft_timer lft_timer_properties u_props (.i_clk, .i_reset, .i_addr, .i_wdata, .i_wr,
   .i_rd, .o_rdata, .o_osc_input_pin_oe, .o_osc_output_pin_oe, .o_sec_osc_enable, .o_count);

//--- bench/lft_timer_tb.sv
`timescale 1ns/1ps
module lft_timer_tb
   import lft_pkg::*;
;
   typedef struct {logic [7:0] ctrl; int cyc; logic [15:0] exp;} lft_row_t;
   logic i_clk, i_reset, i_wr, i_rd, dev, ext_en, ext_pin;
   logic in_oe, out_oe, in_v, out_v, osc_en;
   logic [1:0]  i_addr;
   logic [1:0]  pdir, pout;
   logic [7:0]  i_wdata, o_rdata;
   logic [15:0] o_count;
   wire         in_pin  = in_oe ? in_v : 1'b1;
   wire         out_pin = out_oe ? out_v : ext_pin;
   int          mismatches = 0;
   int          tests_run = 0;
   lft_row_t    rows [8] = '{'{8'h01, 20, 5}, '{8'h15, 42, 5}, '{8'h21, 86, 5},
      '{8'h3d, 174, 5}, '{8'hc3, 48, 5}, '{8'hc7, 48, 5}, '{8'hcb, 48, 5}, '{8'h13, 103, 5}};

   lft_timer dut (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_devclk_from_osc(dev),
      .i_port_direction(pdir), .i_port_out(pout), .i_osc_input_pin(in_pin),
      .o_osc_input_pin(in_v), .o_osc_input_pin_oe(in_oe), .i_osc_output_pin(out_pin),
      .o_osc_output_pin(out_v), .o_osc_output_pin_oe(out_oe), .o_sec_osc_enable(osc_en),
      .o_count(o_count));
   lft_ext_clock_model ext (.i_clk(i_clk), .i_en(ext_en), .o_pin(ext_pin));

   task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", name, e, g);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge i_clk) {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
      @(posedge i_clk) i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a, input logic [7:0] e);
      @(posedge i_clk) {i_rd, i_addr} <= {1'b1, a};
      @(posedge i_clk) i_rd <= 1'b0;
      #1 chk("read data", {8'h00, e}, {8'h00, o_rdata});
   endtask
   task automatic finish_test();
      $display("Comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end
   initial begin
      repeat (20000) @(posedge i_clk);
      mismatches++;
      finish_test();
   end
   initial begin
      {i_reset, i_wr, i_rd, dev, ext_en, i_addr, i_wdata} = {5'h10, 2'h0, 8'h00};
      {pdir, pout} = 4'hc;
      repeat (4) @(posedge i_clk);
      i_reset <= 1'b0;
      foreach (rows[i]) begin
         wr(LFT_ADDR_CNT_L, 8'h00);
         wr(LFT_ADDR_CNT_H, 8'h00);
         if (rows[i].ctrl[3]) begin
            wr(LFT_ADDR_CTRL, 8'h08);
            repeat (20) @(posedge i_clk);
         end
         ext_en <= rows[i].ctrl[1];
         wr(LFT_ADDR_CTRL, rows[i].ctrl);
         rd(LFT_ADDR_PORT, 8'h00);
         chk("osc enable", {15'h0, rows[i].ctrl[3]}, {15'h0, osc_en});
         repeat (rows[i].cyc - 2) @(posedge i_clk);
         wr(LFT_ADDR_CTRL, 8'h00);
         ext_en <= 1'b0;
         rd(LFT_ADDR_CNT_L, rows[i].exp[7:0]);
         $display("Row %0d done", i);
      end
      wr(LFT_ADDR_CTRL, 8'h80);
      wr(LFT_ADDR_CNT_H, 8'h12);
      #1 chk("count", rows[7].exp, o_count);
      wr(LFT_ADDR_CNT_L, 8'h34);
      #1 chk("count", 16'h1234, o_count);
      rd(LFT_ADDR_CNT_L, 8'h34);
      rd(LFT_ADDR_CNT_H, 8'h12);
      wr(LFT_ADDR_CTRL, 8'h00);
      wr(LFT_ADDR_CNT_H, 8'hab);
      #1 chk("count", 16'hab34, o_count);
      $display("Access test done");
      dev <= 1'b1;
      wr(LFT_ADDR_CTRL, 8'hbe);
      rd(LFT_ADDR_CTRL, 8'hfe);
      dev <= 1'b0;
      wr(LFT_ADDR_CTRL, 8'h40);
      rd(LFT_ADDR_CTRL, 8'h00);
      rd(LFT_ADDR_PORT, 8'h02);
      $display("Status test done");
      @(posedge i_clk) {pdir, pout} <= 4'h1;
      repeat (3) @(posedge i_clk);
      #1 chk("pin drive", 16'h000d, {12'h000, in_oe, out_oe, in_v, out_v});
      rd(LFT_ADDR_PORT, 8'h01);
      wr(LFT_ADDR_CTRL, 8'h01);
      #1 chk("pin drive", 16'h0001, {12'h000, in_oe, out_oe, in_v, out_v});
      rd(LFT_ADDR_PORT, 8'h00);
      wr(LFT_ADDR_CTRL, 8'h00);
      $display("Pin test done");
      wr(LFT_ADDR_CTRL, 8'h01);
      i_reset <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_reset <= 1'b0;
      rd(LFT_ADDR_CTRL, 8'h00);
      chk("count", 16'h0000, o_count);
      $display("Reset test done");
      finish_test();
   end
endmodule

//--- verilog/lft_pkg.sv
package lft_pkg;

   // Register map
   localparam logic [1:0] LFT_ADDR_CTRL  = 2'h0;
   localparam logic [1:0] LFT_ADDR_CNT_L = 2'h1;
   localparam logic [1:0] LFT_ADDR_CNT_H = 2'h2;
   localparam logic [1:0] LFT_ADDR_PORT  = 2'h3;

   // Control field positions
   localparam int LFT_BIT_WIDE   = 7;
   localparam int LFT_BIT_OSCRUN = 6;
   localparam int LFT_BIT_PS_HI  = 5;
   localparam int LFT_BIT_PS_LO  = 4;
   localparam int LFT_BIT_OSCEN  = 3;
   localparam int LFT_BIT_NOSYNC = 2;
   localparam int LFT_BIT_CS     = 1;
   localparam int LFT_BIT_RUN    = 0;

   // Reset values
   localparam logic [7:0]  LFT_CTRL_RESET  = 8'h00;
   localparam logic [15:0] LFT_COUNT_RESET = 16'h0000;

   // Prescale codes and terminal counts
   localparam logic [1:0] LFT_PS_DIV1 = 2'h0;
   localparam logic [1:0] LFT_PS_DIV2 = 2'h1;
   localparam logic [1:0] LFT_PS_DIV4 = 2'h2;
   localparam logic [1:0] LFT_PS_DIV8 = 2'h3;
   localparam logic [2:0] LFT_PS_TERM1 = 3'h0;
   localparam logic [2:0] LFT_PS_TERM2 = 3'h1;
   localparam logic [2:0] LFT_PS_TERM4 = 3'h3;
   localparam logic [2:0] LFT_PS_TERM8 = 3'h7;

   // Internal clock is the main clock divided by four
   localparam logic [1:0] LFT_INT_DIV_TERM = 2'h3;

   typedef enum logic [1:0] {
      LFT_MODE_TIMER,
      LFT_MODE_SYNC_CNT,
      LFT_MODE_ASYNC_CNT
   } lft_mode_t;

endpackage

//--- verilog/lft_prescaler.sv
`timescale 1ns/1ps
module lft_prescaler
   import lft_pkg::*;
(
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_reset,
   // Control
   input  wire logic       i_clear,
   input  wire logic [1:0] i_sel,
   // Ticks
   input  wire logic       i_tick,
   output logic            o_tick
);

   typedef struct packed {
      logic [2:0] cnt;
      logic       tick;
   } lft_ps_state_t;

   lft_ps_state_t st;
   lft_ps_state_t next_st;
   logic [2:0]    term;

   always_comb begin
      case (i_sel)
         LFT_PS_DIV1: term = LFT_PS_TERM1;
         LFT_PS_DIV2: term = LFT_PS_TERM2;
         LFT_PS_DIV4: term = LFT_PS_TERM4;
         LFT_PS_DIV8: term = LFT_PS_TERM8;
         default:     term = LFT_PS_TERM1;
      endcase
      next_st = st;
      next_st.tick = 1'b0;
      if (i_clear) begin
         next_st.cnt = 3'h0;
      end else if (i_tick) begin
         if (st.cnt >= term) begin
            next_st.cnt  = 3'h0;
            next_st.tick = 1'b1;
         end else begin
            next_st.cnt = st.cnt + 3'h1;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_tick = st.tick;

endmodule

//--- verilog/lft_timer.sv
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ps
module lft_timer
   import lft_pkg::*;
(
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_reset,
   // Register port
   input  wire logic [1:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic      [7:0] o_rdata,
   // Device clock status from clock switch
   input  wire logic       i_devclk_from_osc,
   // Port direction and output latch, bit 1 input pin, bit 0 output pin
   input  wire logic [1:0] i_port_direction,
   input  wire logic [1:0] i_port_out,
   // Oscillator input pin
   input  wire logic       i_osc_input_pin,
   output logic            o_osc_input_pin,
   output logic            o_osc_input_pin_oe,
   // Oscillator output pin, also external clock
   input  wire logic       i_osc_output_pin,
   output logic            o_osc_output_pin,
   output logic            o_osc_output_pin_oe,
   // Oscillator and count status
   output logic            o_sec_osc_enable,
   output logic     [15:0] o_count
);

   typedef struct packed {
      logic        wide_access_enable;
      logic [1:0]  prescale_select;
      logic        sec_osc_enable;
      logic        ext_sync_disable;
      logic        clock_source_select;
      logic        timer_run;
      logic        stat_s1;
      logic        stat_s2;
      logic        in_s1;
      logic        in_s2;
      logic        out_s1;
      logic        out_s2;
      logic        out_s3;
      logic        out_s4;
      logic [1:0]  qdiv;
      logic [15:0] count;
      logic [7:0]  hi_buf;
      logic [7:0]  rdata;
      logic        in_pin;
      logic        in_pin_oe;
      logic        out_pin;
      logic        out_pin_oe;
   } lft_state_t;

   lft_state_t st;
   lft_state_t next_st;
   lft_mode_t  mode;
   logic       src_tick;
   logic       pre_tick;
   logic [7:0] ctrl_view;

   // Mode decode
   always_comb begin
      if (!st.clock_source_select) begin
         mode = LFT_MODE_TIMER;
      end else if (st.ext_sync_disable) begin
         mode = LFT_MODE_ASYNC_CNT;
      end else begin
         mode = LFT_MODE_SYNC_CNT;
      end
   end

   // Source tick per mode
   always_comb begin
      case (mode)
         LFT_MODE_TIMER:     src_tick = (st.qdiv == LFT_INT_DIV_TERM);
         LFT_MODE_SYNC_CNT:  src_tick = st.out_s3 & ~st.out_s4;
         LFT_MODE_ASYNC_CNT: src_tick = st.out_s2 & ~st.out_s3;
         default:            src_tick = 1'b0;
      endcase
   end

   lft_prescaler u_prescaler (
      .i_clk   (i_clk),
      .i_reset (i_reset),
      .i_clear (~st.timer_run),
      .i_sel   (st.prescale_select),
      .i_tick  (src_tick & st.timer_run),
      .o_tick  (pre_tick)
   );

   // Control register as read
   always_comb begin
      ctrl_view = LFT_CTRL_RESET;
      ctrl_view[LFT_BIT_WIDE]   = st.wide_access_enable;
      ctrl_view[LFT_BIT_OSCRUN] = st.stat_s2;
      ctrl_view[LFT_BIT_PS_HI]  = st.prescale_select[1];
      ctrl_view[LFT_BIT_PS_LO]  = st.prescale_select[0];
      ctrl_view[LFT_BIT_OSCEN]  = st.sec_osc_enable;
      ctrl_view[LFT_BIT_NOSYNC] = st.ext_sync_disable;
      ctrl_view[LFT_BIT_CS]     = st.clock_source_select;
      ctrl_view[LFT_BIT_RUN]    = st.timer_run;
   end

   always_comb begin
      next_st = st;

      // Pin and status synchronisers
      next_st.stat_s1 = i_devclk_from_osc;
      next_st.stat_s2 = st.stat_s1;
      next_st.in_s1   = i_osc_input_pin;
      next_st.in_s2   = st.in_s1;
      next_st.out_s1  = i_osc_output_pin;
      next_st.out_s2  = st.out_s1;
      next_st.out_s3  = st.out_s2;
      next_st.out_s4  = st.out_s3;

      // Internal clock at a quarter of the main clock
      if (st.timer_run) begin
         next_st.qdiv = st.qdiv + 2'h1;
      end else begin
         next_st.qdiv = 2'h0;
      end

      // Counting
      if (pre_tick && st.timer_run) begin
         next_st.count = st.count + 16'h0001;
      end

      // Register reads
      next_st.rdata = 8'h00;
      if (i_rd) begin
         case (i_addr)
            LFT_ADDR_CTRL: begin
               next_st.rdata = ctrl_view;
            end
            LFT_ADDR_CNT_L: begin
               next_st.rdata = st.count[7:0];
               if (st.wide_access_enable) begin
                  next_st.hi_buf = st.count[15:8];
               end
            end
            LFT_ADDR_CNT_H: begin
               if (st.wide_access_enable) begin
                  next_st.rdata = st.hi_buf;
               end else begin
                  next_st.rdata = st.count[15:8];
               end
            end
            LFT_ADDR_PORT: begin
               if (st.timer_run) begin
                  next_st.rdata = 8'h00;
               end else begin
                  next_st.rdata = {6'h00, st.in_s2, st.out_s2};
               end
            end
            default: begin
               next_st.rdata = 8'h00;
            end
         endcase
      end

      // Register writes, a count write wins over the increment in the bytes that it writes
      if (i_wr) begin
         case (i_addr)
            LFT_ADDR_CTRL: begin
               next_st.wide_access_enable  = i_wdata[LFT_BIT_WIDE];
               next_st.prescale_select     = i_wdata[LFT_BIT_PS_HI:LFT_BIT_PS_LO];
               next_st.sec_osc_enable      = i_wdata[LFT_BIT_OSCEN];
               next_st.ext_sync_disable    = i_wdata[LFT_BIT_NOSYNC];
               next_st.clock_source_select = i_wdata[LFT_BIT_CS];
               next_st.timer_run           = i_wdata[LFT_BIT_RUN];
            end
            LFT_ADDR_CNT_L: begin
               if (st.wide_access_enable) begin
                  next_st.count = {st.hi_buf, i_wdata};
               end else begin
                  next_st.count[7:0] = i_wdata;
               end
            end
            LFT_ADDR_CNT_H: begin
               if (st.wide_access_enable) begin
                  next_st.hi_buf = i_wdata;
               end else begin
                  next_st.count[15:8] = i_wdata;
               end
            end
            default: begin
               next_st.hi_buf = next_st.hi_buf;
            end
         endcase
      end

      // Pin drive, forced to inputs while running
      next_st.in_pin     = i_port_out[1];
      next_st.out_pin    = i_port_out[0];
      next_st.in_pin_oe  = ~next_st.timer_run & ~i_port_direction[1];
      next_st.out_pin_oe = ~next_st.timer_run & ~i_port_direction[0];
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         st                     <= '0;
         st.wide_access_enable  <= LFT_CTRL_RESET[LFT_BIT_WIDE];
         st.prescale_select     <= LFT_CTRL_RESET[LFT_BIT_PS_HI:LFT_BIT_PS_LO];
         st.sec_osc_enable      <= LFT_CTRL_RESET[LFT_BIT_OSCEN];
         st.ext_sync_disable    <= LFT_CTRL_RESET[LFT_BIT_NOSYNC];
         st.clock_source_select <= LFT_CTRL_RESET[LFT_BIT_CS];
         st.timer_run           <= LFT_CTRL_RESET[LFT_BIT_RUN];
         st.count               <= LFT_COUNT_RESET;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from flops
   assign o_rdata             = st.rdata;
   assign o_osc_input_pin     = st.in_pin;
   assign o_osc_input_pin_oe  = st.in_pin_oe;
   assign o_osc_output_pin    = st.out_pin;
   assign o_osc_output_pin_oe = st.out_pin_oe;
   assign o_sec_osc_enable    = st.sec_osc_enable;
   assign o_count             = st.count;

endmodule
